// *** ddl_sync.sv ***
// constants for the dual converter latch control and a two-flop synchroniser
`default_nettype none

package ddl_pkg;
    // width of the shared parallel data port
    localparam int DW = 12;
    // all-ones code, used to form the complementary output code
    localparam logic [11:0] CODE_MAX = 12'hfff;
    // idle code held in the latches after reset
    localparam logic [11:0] CODE_ZERO = 12'h000;
    // levels that the pins float to when left open (normal operation)
    localparam logic DEF_POWER_OFF = 1'b0;
    localparam logic DEF_STANDBY_SEL = 1'b1;
    localparam logic DEF_CS_N = 1'b0;
    localparam logic DEF_VPOWER_OFF = 1'b0;
    localparam logic DEF_CLK = 1'b0;
    // bit positions inside the synchronised pin vector
    localparam int POS_VPOWER_OFF = 0;
    localparam int POS_STANDBY_SEL = 1;
    localparam int POS_POWER_OFF = 2;
    localparam int POS_CS_N = 3;
    localparam int POS_CLK = 4;
    localparam int POS_DATA = 5;
    // width of the synchronised pin vector
    localparam int SW = DW + 5;
    // reset value of the synchronised pin vector
    localparam logic [SW-1:0] SYNC_RST = {CODE_ZERO, DEF_CLK, DEF_CS_N,
        DEF_POWER_OFF, DEF_STANDBY_SEL, DEF_VPOWER_OFF};
endpackage : ddl_pkg

module ddl_sync
    import ddl_pkg::*;
#(
    parameter int W = SW,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // first stage, read only by the second stage
    logic [W-1:0] meta;

    // two flip-flops per bit, reset to the RST value
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            meta <= RST;
            q <= RST;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : ddl_sync

`default_nettype wire

// *** ddl_top.sv ***
// input latch and mode control of the dual current converter
// Notes on behaviour
// - channel one on rising, two on falling
// - rising edge outputs stored pair together
// - active mode: latch clock follows input clock
// - chip select high: no data capture
// - chip select sampled at rising; high holds clock
// - after select low: falling, then rising outputs
// - standby keeps capturing, outputs stay frozen
// - standby with select high: gated, outputs off
// - standby released: outputs resume earlier state
// - select high, no standby: hold last output
// - full power-down: outputs off, clock gated; here only the current outputs go off, voltage outputs follow their own pin
// - voltage power-down pin disables voltage outputs
// - open mode pins give normal operation
// - codes unsigned, complement carries remainder
// - straight offset binary coding of codes
`default_nettype none

module ddl_top
    import ddl_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic DATA_CLK,
    input wire logic [DW-1:0] DATA_IN,
    input wire logic CS_N,
    input wire logic FULL_POWER_DOWN,
    input wire logic STANDBY_SELECT,
    input wire logic VOLTAGE_CONV_POWER_DOWN,
    output logic [DW-1:0] TRUE_CURRENT_OUTPUT1,
    output logic [DW-1:0] TRUE_CURRENT_OUTPUT2,
    output logic [DW-1:0] COMP_CURRENT_OUTPUT1,
    output logic [DW-1:0] COMP_CURRENT_OUTPUT2,
    output logic CURRENT_OUT_ENABLE,
    output logic VOLTAGE_OUT_ENABLE,
    output logic LATCH_CLK
);
    // whole state of the block
    typedef struct packed {
        logic clk_q;            // delayed copy of the synced input clock
        logic gate_hold;        // latch clock held high by select/power-down
        logic lclk;             // internal latch clock
        logic [DW-1:0] ch1;     // channel one input latch
        logic [DW-1:0] ch2;     // channel two input latch
        logic [DW-1:0] out1;    // channel one converter code
        logic [DW-1:0] out2;    // channel two converter code
        logic [DW-1:0] cmp1;    // channel one complementary code
        logic [DW-1:0] cmp2;    // channel two complementary code
        logic i_en;             // current outputs driven
        logic v_en;             // voltage outputs driven
    } ddl_state_s;

    ddl_state_s st;             // registered state
    ddl_state_s next_st;        // next state
    logic [SW-1:0] pins;        // raw pin vector
    logic [SW-1:0] syn;         // synchronised pin vector
    logic clk_s;                // synced input clock
    logic cs_n_s;               // synced active-low chip select
    logic poff_s;               // synced full power-down
    logic ssel_s;               // synced standby select, low = standby
    logic vpoff_s;              // synced voltage power-down
    logic [DW-1:0] data_s;      // synced data word
    logic rise;                 // rising edge of the input clock
    logic fall;                 // falling edge of the input clock
    logic open_gate;            // capture allowed: gate not held, no power-down

    // every pin passes two flops; reset values are the open-pin levels
    assign pins = {DATA_IN, DATA_CLK, CS_N, FULL_POWER_DOWN,
                   STANDBY_SELECT, VOLTAGE_CONV_POWER_DOWN};

    // data rides with the clock so both see the same delay
    ddl_sync #(.W(SW), .RST(SYNC_RST)) u_sync (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .d(pins),
        .q(syn)
    );

    assign clk_s = syn[POS_CLK];
    assign cs_n_s = syn[POS_CS_N];
    assign poff_s = syn[POS_POWER_OFF];
    assign ssel_s = syn[POS_STANDBY_SEL];
    assign vpoff_s = syn[POS_VPOWER_OFF];
    assign data_s = syn[POS_DATA +: DW];
    assign rise = clk_s & ~st.clk_q;
    assign fall = ~clk_s & st.clk_q;
    // power-down stops capture at once, chip select waits for a rise
    assign open_gate = ~st.gate_hold & ~poff_s;

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.clk_q = clk_s;
        // the gate hold takes select and power-down only on a rising edge
        if (rise) begin
            next_st.gate_hold = cs_n_s | poff_s;
        end
        // a held gate keeps the latch clock high, else it follows
        next_st.lclk = next_st.gate_hold | clk_s;
        // rising edge with the gate open: output pair, take channel one
        if (rise && open_gate) begin
            next_st.ch1 = data_s;
            // standby or power-down freezes the converter codes
            if (ssel_s && !poff_s) begin
                next_st.out1 = st.ch1;
                next_st.out2 = st.ch2;
                next_st.cmp1 = st.ch1 ^ CODE_MAX;
                next_st.cmp2 = st.ch2 ^ CODE_MAX;
            end
        end
        // falling edge with the gate open takes channel two
        if (fall && open_gate) begin
            next_st.ch2 = data_s;
        end
        // current outputs off in standby or full power-down
        next_st.i_en = ssel_s & ~poff_s;
        // voltage section follows its own pin only
        next_st.v_en = ~vpoff_s;
    end

    // state register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st.clk_q <= DEF_CLK;
            st.gate_hold <= DEF_CS_N | DEF_POWER_OFF;
            st.lclk <= DEF_CS_N | DEF_POWER_OFF | DEF_CLK;
            st.ch1 <= CODE_ZERO;
            st.ch2 <= CODE_ZERO;
            st.out1 <= CODE_ZERO;
            st.out2 <= CODE_ZERO;
            st.cmp1 <= CODE_MAX;
            st.cmp2 <= CODE_MAX;
            st.i_en <= DEF_STANDBY_SEL & ~DEF_POWER_OFF;
            st.v_en <= ~DEF_VPOWER_OFF;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign TRUE_CURRENT_OUTPUT1 = st.out1;
    assign TRUE_CURRENT_OUTPUT2 = st.out2;
    assign COMP_CURRENT_OUTPUT1 = st.cmp1;
    assign COMP_CURRENT_OUTPUT2 = st.cmp2;
    assign CURRENT_OUT_ENABLE = st.i_en;
    assign VOLTAGE_OUT_ENABLE = st.v_en;
    assign LATCH_CLK = st.lclk;

    // channel one captured on an open rising edge
    chk_ch1_capture: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        rise && open_gate |=> st.ch1 == $past(data_s))
        else $error("channel one not captured on rising edge");

    // channel two captured on an open falling edge
    chk_ch2_capture: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        fall && open_gate |=> st.ch2 == $past(data_s))
        else $error("channel two not captured on falling edge");

    // both codes updated together from the stored pair
    chk_pair_update: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        rise && open_gate && ssel_s |=>
        st.out1 == $past(st.ch1) && st.out2 == $past(st.ch2))
        else $error("output pair not updated together");

    // latch clock still high two cycles after a rising edge with select and power-down low
    chk_lclk_follow: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        !cs_n_s && !poff_s && rise ##1 !cs_n_s && !poff_s |=>
        LATCH_CLK == $past(st.clk_q))
        else $error("latch clock does not follow input clock");

    // held gate stops all capture
    chk_cs_blocks: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        st.gate_hold |=> $stable(st.ch1) && $stable(st.ch2))
        else $error("data captured while chip select held");

    // held gate keeps the last codes so devices can share a bus
    chk_hold_last: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        st.gate_hold |=> $stable(st.out1) && $stable(st.out2))
        else $error("outputs changed while chip select held");

    // select sampled on the rising edge only
    chk_gate_sample: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        rise |=> st.gate_hold == $past(cs_n_s | poff_s) &&
        LATCH_CLK == (st.gate_hold | $past(clk_s)))
        else $error("chip select not sampled on rising edge");

    // standby freezes the converter codes
    chk_standby_freeze: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        !ssel_s |=> $stable(st.out1) && $stable(st.out2))
        else $error("outputs changed during standby");

    // full power-down stops capture without waiting for a rise
    chk_poff_blocks: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        poff_s |=> $stable(st.ch1) && $stable(st.ch2))
        else $error("data captured during full power-down");

    // current outputs off in standby or power-down
    chk_cur_enable: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        ##1 CURRENT_OUT_ENABLE == $past(ssel_s && !poff_s))
        else $error("current output enable wrong");

    // voltage outputs follow their own power-down pin
    chk_volt_enable: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        ##1 VOLTAGE_OUT_ENABLE == !$past(vpoff_s))
        else $error("voltage output enable wrong");

    // complementary code carries the remainder
    chk_comp_code: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        $changed(st.out1) |-> (st.out1 ^ st.cmp1) == CODE_MAX)
        else $error("complementary code mismatch");

    // channel two complement is full scale minus the code
    chk_comp_two: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        $changed(st.out2) |-> st.cmp2 == CODE_MAX - st.out2)
        else $error("channel two complementary code mismatch");
endmodule : ddl_top

`default_nettype wire

// *** ddl_host.sv ***
// host data source model driving the shared parallel bus
`default_nettype none
module ddl_host
    import ddl_pkg::*;
#(
    parameter int H = 8
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [DW-1:0] word,
    output logic DATA_CLK,
    output logic [DW-1:0] DATA_IN
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt; // place inside one half period
    // data moves mid-phase, away from the data clock edge
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt <= 0;
            DATA_CLK <= 1'b0;
            DATA_IN <= 12'h000;
        end else begin
            cnt <= (cnt + 1) % H;
            // words come already in channel one, channel two order
            if (cnt == 4) DATA_IN <= word;
            if (cnt == H - 1) DATA_CLK <= ~DATA_CLK;
        end
    end
endmodule // ddl_host
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the dual converter latch control
`default_nettype none
module tb
    import ddl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // mode pins and data word driven by the bench
    logic CLK = 1'b0, ARST_N = 1'b0, CS_N = 1'b0, power_off = 1'b0;
    logic standby_sel = 1'b1, vpower_off = 1'b0;
    logic [DW-1:0] word = 12'h000, c1 = 12'h000, c2 = 12'h000;
    logic [DW-1:0] o1 = 12'h000, o2 = 12'h000;
    logic [DW-1:0] t1, t2, k1, k2, DATA_IN;
    logic ce, ve, lc, DATA_CLK, last = 1'b0, g = 1'b0;
    logic [15:0] lf = 16'h000a; // random source state
    int fails = 0, cmp_count = 0;
    always #50 CLK = ~CLK;
    ddl_host #(.H(8)) host (.CLK(CLK), .ARST_N(ARST_N), .word(word),
        .DATA_CLK(DATA_CLK), .DATA_IN(DATA_IN));
    ddl_top DUT (.CLK(CLK), .ARST_N(ARST_N), .DATA_CLK(DATA_CLK),
        .DATA_IN(DATA_IN), .CS_N(CS_N), .FULL_POWER_DOWN(power_off),
        .STANDBY_SELECT(standby_sel), .VOLTAGE_CONV_POWER_DOWN(vpower_off),
        .TRUE_CURRENT_OUTPUT1(t1), .TRUE_CURRENT_OUTPUT2(t2),
        .COMP_CURRENT_OUTPUT1(k1), .COMP_CURRENT_OUTPUT2(k2),
        .CURRENT_OUT_ENABLE(ce), .VOLTAGE_OUT_ENABLE(ve), .LATCH_CLK(lc));
    // next random value
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // hand-picked corner codes among the random words
    function automatic logic [DW-1:0] pick(input int s, logic [DW-1:0] r);
        if (s == 2) return CODE_MAX;
        if (s == 3) return 12'h800;
        if (s == 4) return CODE_ZERO;
        return r;
    endfunction
    // mode pins per step as {full power-down, standby select,
    // chip select, voltage power-down}
    function automatic logic [3:0] mode(input int s);
        if (s >= 10 && s < 16) return 4'h6;
        if (s >= 24 && s < 32) return 4'h0;
        if (s >= 32 && s < 34) return 4'h2;
        if (s >= 42 && s < 44) return 4'hc;
        if (s >= 44 && s < 46) return 4'he;
        if (s >= 46 && s < 50) return 4'h5;
        return 4'h4;
    endfunction
    task automatic cmp_code(input logic [DW-1:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: code %h not %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // reference latches, updated at every data clock edge
    always @(posedge CLK) begin
        if (ARST_N && DATA_CLK != last) begin
            if (DATA_CLK) begin
                if (!g && !power_off) begin
                    if (standby_sel) {o1, o2} = {c1, c2};
                    c1 = DATA_IN;
                end
                g = CS_N | power_off;
            end else if (!g && !power_off) c2 = DATA_IN;
        end
        last = DATA_CLK;
    end
    // main sequence: one step per data clock half period
    initial begin
        logic d0;
        int w;
        repeat (4) @(posedge CLK);
        ARST_N <= 1'b1;
        @(negedge CLK);
        cmp_bit(ce, 1'b1);
        cmp_bit(ve, 1'b1);
        for (int s = 0; s < 60; s++) begin
            d0 = DATA_CLK;
            for (w = 0; w < 20 && DATA_CLK == d0; w++) @(posedge CLK);
            if (w == 20) fails++;
            repeat (3) @(posedge CLK);
            @(negedge CLK);
            cmp_code(t1, o1);
            cmp_code(t2, o2);
            cmp_code(k1, CODE_MAX - o1);
            cmp_code(k2, CODE_MAX - o2);
            cmp_bit(ce, standby_sel & ~power_off);
            cmp_bit(ve, ~vpower_off);
            cmp_bit(lc, g | DATA_CLK);
            @(posedge CLK);
            {power_off, standby_sel, CS_N, vpower_off} <= mode(s);
            lf = lfsr(lf);
            word <= pick(s, lf[DW-1:0]);
        end
        give_verdict;
    end
    // watchdog against a stalled run
    initial begin
        #200000;
        fails++;
        give_verdict;
    end
endmodule // tb
`default_nettype wire
